// ### rebs_checker.sv
// Assertion checker for the rising-edge blank source block
`timescale 1ns/1ns
`include "rebs_defines.svh"
module rebs_checker #(
    parameter int BLANK_W = 8
) (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        external_event_pin,
    input wire logic        comparator1_synced_output,
    input wire logic        pwm_rise_event,
    input wire logic        pin_source_gated,
    input wire logic        cmp1_source_gated,
    input wire logic        cmp2_source_gated,
    input wire logic        cmp3_source_gated,
    input wire logic        blank_active
);
    logic [7:0]         sel_q;
    logic [7:0]         len_q;
    logic [3:0]         ar_q;
    logic [BLANK_W-1:0] cnt_q;
    logic               wr_take;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    // Shadows update at the take edge, one edge early; the bench never writes inside a window
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sel_q <= 8'h00;
            len_q <= 8'h00;
            ar_q <= 4'h0;
            cnt_q <= '0;
        end else begin
            if (wr_take && s_axi_awaddr == `REBS_OFF_SRC_SEL) sel_q <= s_axi_wdata[7:0];
            if (wr_take && s_axi_awaddr == `REBS_OFF_BLANK_LEN) len_q <= s_axi_wdata[7:0];
            if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
            if (pwm_rise_event) cnt_q <= BLANK_W'(len_q);
            else if (cnt_q != '0) cnt_q <= cnt_q - BLANK_W'(1);
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_blank_len: assert property (blank_active == (cnt_q != '0))
        else $error("blank window length wrong");
    chk_pin_hold: assert property (blank_active && sel_q[7] |=> $stable(pin_source_gated))
        else $error("pin source moved while blanked");
    chk_cmp3_hold: assert property (blank_active && sel_q[3] |=> $stable(cmp3_source_gated))
        else $error("comparator 3 moved while blanked");
    chk_cmp2_hold: assert property (blank_active && sel_q[2] |=> $stable(cmp2_source_gated))
        else $error("comparator 2 moved while blanked");
    chk_cmp1_hold: assert property (blank_active && sel_q[1] |=> $stable(cmp1_source_gated))
        else $error("comparator 1 moved while blanked");
    chk_cmp1_pass: assert property (!(blank_active && sel_q[1]) |=> cmp1_source_gated == $past(comparator1_synced_output))
        else $error("comparator 1 not passed through");
    chk_pin_pass: assert property (!sel_q[7] |-> pin_source_gated == $past(external_event_pin, 3))
        else $error("pin not passed through");
    chk_rsv_zero: assert property (s_axi_rvalid && ar_q == `REBS_OFF_SRC_SEL |-> s_axi_rdata[6:4] == 3'h0)
        else $error("unused select bits read nonzero");
endmodule
bind rebs_top rebs_checker #(.BLANK_W(BLANK_W)) u_chk (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .external_event_pin, .comparator1_synced_output, .pwm_rise_event,
    .pin_source_gated, .cmp1_source_gated, .cmp2_source_gated, .cmp3_source_gated, .blank_active);

// ### rebs_defines.svh
// Register map, field positions, reset values and widths of the rising-edge blank source block
`ifndef REBS_DEFINES_SVH
`define REBS_DEFINES_SVH

`define REBS_ADDR_W          4
`define REBS_OFF_SRC_SEL     4'h0
`define REBS_OFF_BLANK_LEN   4'h4
`define REBS_OFF_STATUS      4'h8

`define REBS_BIT_PIN         7
`define REBS_BIT_CMP3        3
`define REBS_BIT_CMP2        2
`define REBS_BIT_CMP1        1
`define REBS_BIT_ACTIVE      16
`define REBS_SRC_SEL_MASK    8'h8E
`define REBS_SRC_SEL_RESET   8'h00
`define REBS_BLANK_LEN_RESET 8'h00

`define REBS_RESP_OKAY       2'h0
`define REBS_RESP_SLVERR     2'h2

`endif

// ### rebs_pkg.sv
// Types shared by the rising-edge blank source block
package rebs_pkg;
    typedef logic [7:0]  rebs_byte_type;
    typedef logic [31:0] rebs_word_type;
    typedef logic [1:0]  rebs_resp_type;
endpackage

// ### rebs_src_model.sv
// Behavioural model of the event pin and the three comparator outputs
`timescale 1ns/1ns
module rebs_src_model (
    input wire logic       clk_sys,
    input wire logic [3:0] lvl,
    output logic           external_event_pin,
    output logic           comparator1_synced_output,
    output logic           comparator2_synced_output,
    output logic           comparator3_synced_output
);
    initial {external_event_pin, comparator3_synced_output, comparator2_synced_output, comparator1_synced_output} = 4'h0;
    // The pin is asynchronous, so it moves away from the edge
    always @(posedge clk_sys) begin
        {comparator3_synced_output, comparator2_synced_output, comparator1_synced_output} <= lvl[2:0];
        external_event_pin <= #3 lvl[3];
    end
endmodule

// ### rebs_top.sv
// Rising-edge blank source selection with AXI4-Lite register slave
//
// Summary of operation
// (R1) Bit 7 set: pin blanked after rise
// (R2) Bit 7 clear: pin passes unblanked
// (R3) Bits 6 to 4 read zero
// (R4) Bit 3 blanks comparator 3 output
// (R5) Bit 2 blanks comparator 2 output
// (R6) Bit 1 blanks comparator 1 output
// (R7) Interval length from blanking duration register
// (R8) Interval starts at rise, counts clocks
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rebs_defines.svh"

module rebs_top #(
    parameter int BLANK_W = 8
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    // AXI4-Lite slave
    input  wire logic [`REBS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`REBS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Event sources and blanking trigger
    input  wire logic                   external_event_pin,
    input  wire logic                   comparator1_synced_output,
    input  wire logic                   comparator2_synced_output,
    input  wire logic                   comparator3_synced_output,
    input  wire logic                   pwm_rise_event,
    // Sources as seen by the event logic
    output logic                        pin_source_gated,
    output logic                        cmp1_source_gated,
    output logic                        cmp2_source_gated,
    output logic                        cmp3_source_gated,
    output logic                        blank_active
);

    // ==========================================================
    // Register write path
    // ==========================================================
    logic                    awready_q, awready_d;
    logic                    wready_q, wready_d;
    logic                    bvalid_q, bvalid_d;
    rebs_pkg::rebs_resp_type bresp_q, bresp_d;
    logic [`REBS_ADDR_W-1:0] waddr_q, waddr_d;
    rebs_pkg::rebs_byte_type wbyte_q, wbyte_d;
    logic                    wstrb0_q, wstrb0_d;
    rebs_pkg::rebs_byte_type src_sel_q, src_sel_d;
    rebs_pkg::rebs_byte_type blank_len_q, blank_len_d;
    logic                    write_fire;

    // A write completes only once both address and data have been taken
    assign write_fire = !awready_q && !wready_q && !bvalid_q;

    always_comb begin
        awready_d   = awready_q;
        wready_d    = wready_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        waddr_d     = waddr_q;
        wbyte_d     = wbyte_q;
        wstrb0_d    = wstrb0_q;
        src_sel_d   = src_sel_q;
        blank_len_d = blank_len_q;
        if (awready_q && s_axi_awvalid) begin
            awready_d = 1'b0;
            waddr_d   = s_axi_awaddr;
        end
        if (wready_q && s_axi_wvalid) begin
            wready_d = 1'b0;
            wbyte_d  = s_axi_wdata[7:0];
            wstrb0_d = s_axi_wstrb[0];
        end
        if (write_fire) begin
            bvalid_d = 1'b1;
            bresp_d  = `REBS_RESP_OKAY;
            unique case (waddr_q)
                `REBS_OFF_SRC_SEL: begin
                    // Unimplemented positions are never stored
                    if (wstrb0_q) begin
                        src_sel_d = wbyte_q & `REBS_SRC_SEL_MASK; // R3
                    end
                end
                `REBS_OFF_BLANK_LEN: begin
                    if (wstrb0_q) begin
                        blank_len_d = wbyte_q;
                    end
                end
                `REBS_OFF_STATUS: begin
                    bresp_d = `REBS_RESP_OKAY;
                end
                default: begin
                    bresp_d = `REBS_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d  = 1'b0;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awready_q   <= 1'b1;
            wready_q    <= 1'b1;
            bvalid_q    <= 1'b0;
            bresp_q     <= `REBS_RESP_OKAY;
            waddr_q     <= '0;
            wbyte_q     <= 8'h00;
            wstrb0_q    <= 1'b0;
            src_sel_q   <= `REBS_SRC_SEL_RESET;
            blank_len_q <= `REBS_BLANK_LEN_RESET;
        end else begin
            awready_q   <= awready_d;
            wready_q    <= wready_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            waddr_q     <= waddr_d;
            wbyte_q     <= wbyte_d;
            wstrb0_q    <= wstrb0_d;
            src_sel_q   <= src_sel_d;
            blank_len_q <= blank_len_d;
        end
    end

    // ==========================================================
    // Register read path
    // ==========================================================
    logic                    arready_q, arready_d;
    logic                    rvalid_q, rvalid_d;
    rebs_pkg::rebs_word_type rdata_q, rdata_d;
    rebs_pkg::rebs_resp_type rresp_q, rresp_d;
    logic [BLANK_W-1:0]      cnt_q, cnt_d;

    always_comb begin
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (arready_q && s_axi_arvalid) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = `REBS_RESP_OKAY;
            rdata_d   = 32'h0000_0000;
            unique case (s_axi_araddr)
                `REBS_OFF_SRC_SEL: begin
                    rdata_d[7:0] = src_sel_q & `REBS_SRC_SEL_MASK; // R3
                end
                `REBS_OFF_BLANK_LEN: begin
                    rdata_d[7:0] = blank_len_q;
                end
                `REBS_OFF_STATUS: begin
                    // Live countdown and active flag for software
                    rdata_d[BLANK_W-1:0] = cnt_q;
                    rdata_d[`REBS_BIT_ACTIVE] = (cnt_q != '0);
                end
                default: begin
                    rresp_d = `REBS_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `REBS_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // ==========================================================
    // Blanking interval and source gating
    // ==========================================================
    logic pin_meta_q, pin_sync_q;
    logic pin_g_q, pin_g_d;
    logic c1_g_q, c1_g_d;
    logic c2_g_q, c2_g_d;
    logic c3_g_q, c3_g_d;
    logic active;
    logic blank_q, blank_d;

    // Gate a source: while blanked it holds its last level, so no edge can leak through.
    // Forcing it low instead would itself manufacture a falling event.
    function automatic logic gate_src(input logic sel, input logic held, input logic live);
        gate_src = (active && sel) ? held : live;
    endfunction

    assign active = (cnt_q != '0);

    always_comb begin
        cnt_d = cnt_q;
        if (pwm_rise_event) begin
            // A new rise restarts the window; zero length means no blanking
            cnt_d = blank_len_q[BLANK_W-1:0]; // R7 R8
        end else if (active) begin
            cnt_d = cnt_q - BLANK_W'(1); // R8
        end
        // Registered copy of the window flag so the output comes from a flop
        blank_d = (cnt_d != '0); // R8
        pin_g_d = gate_src(src_sel_q[`REBS_BIT_PIN], pin_g_q, pin_sync_q);                // R1 R2
        c3_g_d  = gate_src(src_sel_q[`REBS_BIT_CMP3], c3_g_q, comparator3_synced_output); // R4
        c2_g_d  = gate_src(src_sel_q[`REBS_BIT_CMP2], c2_g_q, comparator2_synced_output); // R5
        c1_g_d  = gate_src(src_sel_q[`REBS_BIT_CMP1], c1_g_q, comparator1_synced_output); // R6
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            cnt_q      <= '0;
            blank_q    <= 1'b0;
            pin_g_q    <= 1'b0;
            c1_g_q     <= 1'b0;
            c2_g_q     <= 1'b0;
            c3_g_q     <= 1'b0;
        end else begin
            pin_meta_q <= external_event_pin;
            pin_sync_q <= pin_meta_q;
            cnt_q      <= cnt_d;
            blank_q    <= blank_d;
            pin_g_q    <= pin_g_d;
            c1_g_q     <= c1_g_d;
            c2_g_q     <= c2_g_d;
            c3_g_q     <= c3_g_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rdata       = rdata_q;
    assign s_axi_rresp       = rresp_q;
    assign pin_source_gated  = pin_g_q;
    assign cmp1_source_gated = c1_g_q;
    assign cmp2_source_gated = c2_g_q;
    assign cmp3_source_gated = c3_g_q;
    assign blank_active      = blank_q;

endmodule

// ### test_rebs_top.sv
// Self-checking testbench for the rising-edge blank source block
`timescale 1ns/1ns
`include "rebs_defines.svh"
module test_rebs_top;
    logic                    clk_sys = 1'b0;
    logic                    rstn = 1'b0;
    logic [3:0]              s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0, src_lvl = 4'h0;
    rebs_pkg::rebs_word_type s_axi_wdata = 32'h0, s_axi_rdata;
    rebs_pkg::rebs_resp_type s_axi_bresp, s_axi_rresp;
    logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, pwm_rise_event = 1'b0;
    logic                    s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, blank_active;
    logic                    pin_source_gated, cmp1_source_gated, cmp2_source_gated, cmp3_source_gated;
    logic                    external_event_pin, comparator1_synced_output, comparator2_synced_output;
    logic                    comparator3_synced_output;
    int                      mismatches = 0, checks_done = 0;
    rebs_pkg::rebs_byte_type sels[6] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h00, 8'h8E};
    rebs_top dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_event_pin,
        .comparator1_synced_output, .comparator2_synced_output, .comparator3_synced_output, .pwm_rise_event,
        .pin_source_gated, .cmp1_source_gated, .cmp2_source_gated, .cmp3_source_gated, .blank_active);
    rebs_src_model u_src (.clk_sys, .lvl(src_lvl), .external_event_pin, .comparator1_synced_output,
        .comparator2_synced_output, .comparator3_synced_output);
    always #4 clk_sys = ~clk_sys;
    // ==========================================================
    // Tasks
    task automatic cmp(input rebs_pkg::rebs_word_type got, input rebs_pkg::rebs_word_type exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input rebs_pkg::rebs_word_type d, input logic [3:0] strb,
                          input logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        cmp(32'(s_axi_bresp), 32'(resp));
    endtask
    task automatic axi_rd(input logic [3:0] a, input rebs_pkg::rebs_word_type exp, input logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        cmp(s_axi_rdata, exp);
        cmp(32'(s_axi_rresp), 32'(resp));
    endtask
    // Sources flip right after the rise event; selected ones must hold until the window closes
    task automatic blank_run(input rebs_pkg::rebs_byte_type sel);
        logic [3:0] m;
        logic [3:0] old;
        m = {sel[7], sel[3:1]};
        old = src_lvl;
        axi_wr(`REBS_OFF_SRC_SEL, {24'h0, sel}, 4'h1, `REBS_RESP_OKAY);
        @(posedge clk_sys);
        pwm_rise_event <= 1'b1;
        @(posedge clk_sys);
        pwm_rise_event <= 1'b0;
        src_lvl <= ~old;
        repeat (5) @(posedge clk_sys);
        #1;
        cmp(32'(blank_active), 32'h1);
        cmp(32'({pin_source_gated, cmp3_source_gated, cmp2_source_gated, cmp1_source_gated}),
            32'(4'(~(old ^ m))));
        repeat (6) @(posedge clk_sys);
        #1;
        cmp(32'({pin_source_gated, cmp3_source_gated, cmp2_source_gated, cmp1_source_gated}), 32'(4'(~old)));
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        axi_rd(`REBS_OFF_SRC_SEL, 32'h0, `REBS_RESP_OKAY);
        axi_wr(`REBS_OFF_SRC_SEL, 32'hFF, 4'hF, `REBS_RESP_OKAY);
        axi_rd(`REBS_OFF_SRC_SEL, 32'h8E, `REBS_RESP_OKAY);
        axi_wr(`REBS_OFF_BLANK_LEN, 32'h3, 4'hF, `REBS_RESP_OKAY);
        axi_wr(`REBS_OFF_BLANK_LEN, 32'h55, 4'h0, `REBS_RESP_OKAY);
        axi_rd(`REBS_OFF_BLANK_LEN, 32'h3, `REBS_RESP_OKAY);
        axi_wr(`REBS_OFF_STATUS, 32'hFF, 4'hF, `REBS_RESP_OKAY);
        axi_wr(4'hC, 32'hFF, 4'hF, `REBS_RESP_SLVERR);
        axi_rd(`REBS_OFF_STATUS, 32'h0, `REBS_RESP_OKAY);
        axi_rd(4'hC, 32'h0, `REBS_RESP_SLVERR);
        @(posedge clk_sys);
        pwm_rise_event <= 1'b1;
        @(posedge clk_sys);
        pwm_rise_event <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            #1;
            cmp(32'(blank_active), 32'(i < 3));
            @(posedge clk_sys);
        end
        axi_wr(`REBS_OFF_BLANK_LEN, 32'h6, 4'h1, `REBS_RESP_OKAY);
        foreach (sels[i]) blank_run(sels[i]);
        // Countdown seen by software one cycle into a six-cycle window
        @(posedge clk_sys);
        pwm_rise_event <= 1'b1;
        @(posedge clk_sys);
        pwm_rise_event <= 1'b0;
        axi_rd(`REBS_OFF_STATUS, 32'h0001_0005, `REBS_RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        report_and_stop;
    end
endmodule
